// ===== frem_can_node.sv
// Receiving node on the CAN side of the framer
`timescale 1ns/100ps
module frem_can_node (
  input  wire        clk,
  input  wire        rstn,
  input  wire        slow,
  input  wire        frame_valid,
  input  wire [10:0] frame_id,
  input  wire [63:0] frame_data,
  output reg         frame_ready,
  output reg  [10:0] rx_id,
  output reg  [63:0] rx_data,
  output reg  [7:0]  rx_count
);
  reg [2:0] wait_reg;
  // One-cycle accept; a slow node stalls seven cycles to test holding
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frame_ready <= 1'b0;
      wait_reg    <= 3'd0;
      rx_count    <= 8'h00;
    end else begin
      wait_reg    <= frame_valid ? wait_reg + 3'd1 : 3'd0;
      frame_ready <= frame_valid && !frame_ready && (!slow || wait_reg == 3'd6);
      if (frame_valid && frame_ready) begin
        rx_id    <= frame_id;
        rx_count <= rx_count + 8'h01;
        rx_data  <= frame_data[7:0] == 8'h30 ? frame_data & 64'h0000_ff00_ffff_ffff : frame_data;
      end
    end
  end
endmodule // frem_can_node

// ===== frem_framer.v
// Fault lamp sequencer and emergency frame builder
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/100ps
// Summary of operation
// - Nine pulses: 0 flash checksum, n config
// - Runtime bus command error: thirteen, argument 0
// - Wrong terminal format: fourteen, argument n
// - Terminal count changed: fifteen, argument n
// - Bit length changed: sixteen, boot bit length
// - Count mismatch: seventeen, boot terminal count
// - Description mismatch: eighteen, terminal number
// - Location skips passive terminals; the framer leaves this to software and takes the argument as written
// - Frame is code, register, five-byte additional
// - Additional: comm, device, trigger, two parameters
// - Identifier is 0x80 plus node ID
// - Error code low byte 0x00 or 0x30
// - High byte 0x50 device, 0x81 comm, 0x00 reset
// - Register byte 0x81 device, 0x91 comm
// - Comm bits: guard, sync, PDO length, timer
// - Comm bits: rx, tx overrun, bus-off, warning
// - Device bits: terminal, bus, memory, unsupported, altered
// - Cleared error sends code zero with trigger; a later bus-off edge or set-only change before the offer resets clr_pend_reg
// - Send trigger 0x40 after leaving bus-off; a bit change before the frame is offered replaces it
// - Lamp: fast blink, code pulses, argument pulses
`include "frem_map.vh"
module frem_framer (
  input  wire        clk,
  input  wire        rstn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [7:0]  comm_fault_in,
  input  wire [7:0]  device_fault_in,
  input  wire        busoff_left_in,
  output reg         frame_valid,
  input  wire        frame_ready,
  output reg  [10:0] frame_id,
  output reg  [63:0] frame_data,
  output reg         lamp_red
);
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  // Slot lengths in clock cycles; a bench may shrink them to keep runs short
  parameter FAST_CYC = `FREM_FAST_NS / `FREM_CLK_NS;
  parameter SLOW_CYC = `FREM_SLOW_NS / `FREM_CLK_NS;
  // One-hot lamp sequencer states
  localparam L_IDLE = 4'b0001;
  localparam L_FAST = 4'b0010;
  localparam L_CODE = 4'b0100;
  localparam L_ARG  = 4'b1000;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  reg [16:0] sync1_reg;
  reg [16:0] sync2_reg;
  wire [7:0] comm_s   = sync2_reg[7:0];
  wire [7:0] dev_s    = sync2_reg[15:8];
  wire       bo_s     = sync2_reg[16];
  // Fault sources come from other logic on pins; two stages each
  // Nothing but the second stage is read, so a half-settled bit never leaks
  // A change that straddles an edge still gives one frame, with the trigger of the later bit
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= 17'h0_0000;
      sync2_reg <= 17'h0_0000;
    end else begin
      sync1_reg <= {busoff_left_in, device_fault_in, comm_fault_in};
      sync2_reg <= sync1_reg;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Software registers, latched bit fields and frame queue state
  reg [31:0] ctrl_reg;
  reg [12:0] fault_reg;      // [4:0] code, [12:5] argument
  reg        fault_new_reg;
  reg [7:0]  comm_reg;
  reg [7:0]  dev_reg;
  reg        bo_reg;
  reg        pend_reg;
  reg [7:0]  trig_pend_reg;
  reg        clr_pend_reg;   // Pending frame reports a cleared error
  reg [31:0] rd_next;
  // A transfer is taken at the edge where pready is seen high
  wire       acc   = psel & penable & pready;
  wire       wr    = acc & pwrite;
  // Node number and frame enable fields of the control word
  wire [6:0] node  = ctrl_reg[`FREM_CTRL_NODE_MSB:`FREM_CTRL_NODE_LSB];
  wire       fr_en = ctrl_reg[`FREM_CTRL_EN_BIT];

  // Lamp code is accepted only from the documented set
  function code_ok;
    input [4:0] c;
    begin
      code_ok = (c == `FREM_CODE_CONFIG) || (c == `FREM_CODE_CMD) ||
        (c == `FREM_CODE_FORMAT) || (c == `FREM_CODE_COUNT) ||
        (c == `FREM_CODE_BITLEN) || (c == `FREM_CODE_TCOUNT) ||
        (c == `FREM_CODE_DESCR);
    end
  endfunction

  // Trigger for a bit that changed: lowest changed bit number plus one
  function [7:0] trig_of;
    input [15:0] diff;
    integer i;
    begin
      trig_of = 8'h00;
      for (i = 15; i >= 0; i = i - 1) begin
        if (diff[i]) begin
          trig_of = i[7:0] + 8'h01;
        end
      end
    end
  endfunction

  // Read multiplexer; unmapped addresses read zero and flag an error
  always @* begin
    rd_next = 32'h0000_0000;
    case (paddr)
      `FREM_OFF_CTRL:     rd_next = ctrl_reg;
      `FREM_OFF_FAULT:    rd_next = {19'h0_0000, fault_reg};
      // Status: bus-off level, frame pending, frame offered
      `FREM_OFF_STATUS:   rd_next = {29'h0000_0000, bo_reg, pend_reg, frame_valid};
      `FREM_OFF_FRAME_LO: rd_next = frame_data[31:0];
      `FREM_OFF_FRAME_HI: rd_next = frame_data[63:32];
      `FREM_OFF_COMM:     rd_next = {24'h00_0000, comm_reg};
      `FREM_OFF_DEV:      rd_next = {24'h00_0000, dev_reg};
      default:            rd_next = 32'h0000_0000;
    endcase
  end

  // Address decode for the error response
  wire mapped = (paddr == `FREM_OFF_CTRL) || (paddr == `FREM_OFF_FAULT) ||
                (paddr == `FREM_OFF_STATUS) || (paddr == `FREM_OFF_FRAME_LO) ||
                (paddr == `FREM_OFF_FRAME_HI) || (paddr == `FREM_OFF_COMM) ||
                (paddr == `FREM_OFF_DEV);

  // APB slave: one wait state, answer in the second access cycle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready   <= 1'b0;
      prdata   <= 32'h0000_0000;
      pslverr  <= 1'b0;
      ctrl_reg <= `FREM_CTRL_RST;
      fault_reg     <= 13'h0000;
      fault_new_reg <= 1'b0;
    end else begin
      // Answer pulses for one cycle; the low pready guards against a double answer
      pready        <= psel & penable & ~pready;
      pslverr       <= psel & penable & ~pready & ~mapped;
      prdata        <= (psel & penable & ~pready) ? rd_next : 32'h0000_0000;
      fault_new_reg <= 1'b0;
      // Control word: node number and frame enable
      if (wr && paddr == `FREM_OFF_CTRL) begin
        ctrl_reg <= pwdata;
      end
      // Illegal codes are dropped so the lamp never shows a meaningless count
      // Position counting, with passive terminals skipped, is left to software
      // argument as location
      if (wr && paddr == `FREM_OFF_FAULT && (code_ok(pwdata[4:0]) || pwdata[4:0] == 5'd0)) begin
        fault_reg     <= pwdata[12:0];
        fault_new_reg <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Emergency frame builder
  // ---------------------------------------------------------------
  // Change detection against the latched copy of the bit fields
  wire [15:0] now_bits = {dev_s, comm_s};
  wire [15:0] diff     = now_bits ^ {dev_reg, comm_reg};
  wire [15:0] cleared  = diff & ~now_bits;
  wire        bo_edge  = bo_s & ~bo_reg;
  // Frame slot is free and software has enabled sending
  wire        send_ok  = pend_reg & fr_en & (~frame_valid | frame_ready);
  reg  [63:0] fd_next;
  reg  [7:0]  ec_hi;
  reg  [7:0]  ec_lo;
  reg  [7:0]  error_register_byte;

  // Compose the frame from the latched bit fields and pending trigger
  always @* begin
    // register byte
    // Diff is gone by the time the frame is built, so a clear is remembered
    // in clr_pend_reg; the remaining errors still show in the bit fields
    if (clr_pend_reg || (comm_reg == 8'h00 && dev_reg == 8'h00)) begin
      ec_hi = `FREM_EC_HI_RESET;
      error_register_byte  = 8'h00;
    // Comm errors win; the device bytes then mean nothing to a receiver
    end else if (comm_reg != 8'h00) begin
      ec_hi = `FREM_EC_HI_COMM;
      error_register_byte  = `FREM_ERROR_REGISTER_BYTE_COMM;
    end else begin
      ec_hi = `FREM_EC_HI_DEV;
      error_register_byte  = `FREM_ERROR_REGISTER_BYTE_DEV;
    end
    ec_lo = (ec_hi == `FREM_EC_HI_COMM) ? `FREM_EC_LOW_SHORT : `FREM_EC_LOW_FULL;
    fd_next = {8'h00, 8'h00, trig_pend_reg, dev_reg, comm_reg, error_register_byte, ec_hi, ec_lo};
  end

  // Frame queueing: one frame stands until the CAN side takes it
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      comm_reg      <= 8'h00;
      dev_reg       <= 8'h00;
      bo_reg        <= 1'b0;
      pend_reg      <= 1'b0;
      trig_pend_reg <= 8'h00;
      clr_pend_reg  <= 1'b0;
      frame_valid   <= 1'b0;
      frame_id      <= 11'h000;
      frame_data    <= 64'h0000_0000_0000_0000;
    end else begin
      // Latch the synchronised fields; a change shows in diff for one cycle
      // comm bit field
      comm_reg <= comm_s;
      dev_reg  <= dev_s;
      bo_reg   <= bo_s;
      // A change outranks bus-off in the same cycle; a later bus-off edge before the offer still drops a pending clear
      // change queues frame
      if (diff != 16'h0000) begin
        pend_reg      <= 1'b1;
        trig_pend_reg <= trig_of(diff);
        clr_pend_reg  <= (cleared != 16'h0000);
      end else if (bo_edge) begin
        pend_reg      <= 1'b1;
        trig_pend_reg <= `FREM_TRIG_BUSOFF_LEFT;
        clr_pend_reg  <= 1'b0;
      end else if (send_ok) begin
        pend_reg <= 1'b0;
      end
      // Offer a frame only once the fields have settled for a cycle
      if (send_ok && diff == 16'h0000 && !bo_edge) begin
        frame_valid <= 1'b1;
        frame_id    <= `FREM_EMCY_BASE + {4'h0, node};
        frame_data  <= fd_next;
      // The frame leaves once the CAN side takes it
      end else if (frame_ready) begin
        frame_valid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Fault lamp sequencer
  // ---------------------------------------------------------------
  reg [3:0]  lst_reg;
  reg [31:0] tmr_reg;
  reg [8:0]  cnt_reg;
  reg        ph_reg;
  // Slot timer: fast slots in the opening burst, slow slots after it
  wire [31:0] per = (lst_reg == L_FAST) ? FAST_CYC : SLOW_CYC;
  wire        tick = (tmr_reg >= per - 32'd1);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lst_reg  <= L_IDLE;
      tmr_reg  <= 32'h0000_0000;
      cnt_reg  <= 9'h000;
      ph_reg   <= 1'b0;
      lamp_red <= 1'b0;
    end else begin
      // Timer restarts at each slot boundary and when a new indication starts
      tmr_reg <= tick ? 32'h0000_0000 : tmr_reg + 32'd1;
      case (lst_reg)
        // Lamp dark; any nonzero code starts a fresh indication
        L_IDLE: begin
          lamp_red <= 1'b0;
          if (fault_reg[4:0] != 5'd0) begin
            lst_reg <= L_FAST;
            cnt_reg <= {4'h0, `FREM_FAST_PULSES};
            ph_reg  <= 1'b0;
            tmr_reg <= 32'h0000_0000;
          end
        end
        L_FAST, L_CODE, L_ARG: begin
          // Each pulse is one lit slot and one dark slot
          if (tick) begin
            ph_reg   <= ~ph_reg;
            lamp_red <= ~ph_reg & (cnt_reg != 9'h000);
            if (ph_reg) begin
              if (cnt_reg <= 9'h001) begin
                // Next group; an argument of zero gives a dark group, a limitation
                // that keeps the code count readable on its own
                case (lst_reg)
                  L_FAST: begin
                    lst_reg <= L_CODE;
                    cnt_reg <= {4'h0, fault_reg[4:0]};
                  end
                  L_CODE: begin
                    lst_reg <= L_ARG;
                    cnt_reg <= {1'b0, fault_reg[12:5]};
                  end
                  default: begin
                    lst_reg <= L_IDLE;
                    cnt_reg <= 9'h000;
                  end
                endcase
              end else begin
                cnt_reg <= cnt_reg - 9'h001;
              end
            end
          end
          // A rewrite of the fault word restarts the indication at once
          if (fault_new_reg) begin
            lst_reg <= L_IDLE;
          end
        end
        default: lst_reg <= L_IDLE;
      endcase
    end
  end

endmodule // frem_framer

// ===== frem_framer_chk.sv
// Port assertions for the fault framer
`timescale 1ns/100ps
module frem_framer_chk (
  input wire        clk,
  input wire        rstn,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        frame_valid,
  input wire        frame_ready,
  input wire [10:0] frame_id,
  input wire [63:0] frame_data
);
  wire [7:0] lo = frame_data[7:0];
  wire [7:0] hi = frame_data[15:8];
  wire [7:0] er = frame_data[23:16];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Code bytes of every offered frame
  property p_lo; frame_valid |-> lo == 8'h00 || lo == 8'h30; endproperty
  a_lo: assert property (p_lo) else $error("bad code low");
  property p_hi; frame_valid |-> hi == 8'h00 || hi == 8'h50 || hi == 8'h81; endproperty
  a_hi: assert property (p_hi) else $error("bad code high");
  property p_dev; frame_valid && hi == 8'h50 |-> er == 8'h81 && lo == 8'h00; endproperty
  a_dev: assert property (p_dev) else $error("bad device frame");
  property p_comm; frame_valid && hi == 8'h81 |-> er == 8'h91 && lo == 8'h30; endproperty
  a_comm: assert property (p_comm) else $error("bad comm frame");
  property p_clr; frame_valid && hi == 8'h00 |-> er == 8'h00 && lo == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("bad clear frame");
  property p_id; frame_valid |-> frame_id[10:7] == 4'h1; endproperty
  a_id: assert property (p_id) else $error("bad identifier");
  // A stalled frame must not vanish, or the node would lose it
  property p_hold; frame_valid && !frame_ready |=> frame_valid && $stable(frame_id); endproperty
  a_hold: assert property (p_hold) else $error("frame dropped");
  property p_wait; psel && penable && !pready |=> pready ##1 !pready; endproperty
  a_wait: assert property (p_wait) else $error("bus answer wrong");
  c_take: cover property (frame_valid && frame_ready);
  c_comm: cover property (frame_valid && hi == 8'h81);
  c_dev: cover property (frame_valid && hi == 8'h50);
endmodule // frem_framer_chk

bind frem_framer frem_framer_chk i_chk (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pready(pready), .frame_valid(frame_valid), .frame_ready(frame_ready),
  .frame_id(frame_id), .frame_data(frame_data));

// ===== frem_framer_tb.sv
// Self-checking bench for the fault framer
`timescale 1ns/100ps
`include "frem_map.vh"
module frem_framer_tb;
  localparam [15:0] USED = 16'h97ff;
  reg         clk, rstn, psel, penable, pwrite, busoff_left_in, slow, err;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  reg  [7:0]  comm_fault_in, device_fault_in, cnt, arg;
  reg  [15:0] bits_now, rnd;
  reg  [6:0]  node;
  reg  [4:0]  code;
  wire [31:0] prdata;
  wire        pready, pslverr, frame_valid, frame_ready, lamp_red;
  wire [10:0] frame_id, rx_id;
  wire [63:0] frame_data, rx_data;
  wire [7:0]  rx_count;
  integer     seed = 8652, fail_count = 0, checks = 0, fast_n = 0, slow_n = 0, hi_len = 0;
  integer     i, n, f0, s0;
  frem_framer #(.FAST_CYC(4), .SLOW_CYC(16)) i_dut (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comm_fault_in(comm_fault_in),
    .device_fault_in(device_fault_in), .busoff_left_in(busoff_left_in),
    .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_id(frame_id),
    .frame_data(frame_data), .lamp_red(lamp_red));
  frem_can_node i_node (.clk(clk), .rstn(rstn), .slow(slow), .frame_valid(frame_valid),
    .frame_id(frame_id), .frame_data(frame_data), .frame_ready(frame_ready), .rx_id(rx_id),
    .rx_data(rx_data), .rx_count(rx_count));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Pulse width tells fast from slow; slow slots are four times longer
  always @(posedge clk) begin
    if (lamp_red === 1'b1) hi_len = hi_len + 1;
    else if (hi_len > 4) slow_n = slow_n + 1;
    else if (hi_len > 0) fast_n = fast_n + 1;
    if (lamp_red !== 1'b1) hi_len = 0;
  end
  task final_report(input integer lost);
    begin
      fail_count = fail_count + lost;
      $display("checks %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // Every wait is bounded; running out counts as a mismatch
  task tick;
    begin
      n = n + 1;
      if (n > 4000) final_report(1);
      @(posedge clk);
    end
  endtask
  task chk(input [63:0] got, input [63:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
    end
  endtask
  // Request held until pready is sampled high
  task apb(input wr, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      tick;
      while (pready !== 1'b1) tick;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  // Expected frame; trigger is the lowest changed bit plus one
  function [63:0] exp_frame(input [15:0] was, input [15:0] now);
    reg [7:0]  t;
    reg [23:0] h;
    integer    k;
    begin
      t = 8'h00;
      for (k = 15; k >= 0; k = k - 1)
        if (was[k] != now[k]) t = k[7:0] + 8'd1;
      if ((was & ~now) != 16'h0000 || now == 16'h0000) h = 24'h000000;
      else if (now[7:0] != 8'h00) h = 24'h918130;
      else h = 24'h815000;
      exp_frame = {16'h0000, t, now[15:8], now[7:0], h};
      if (h[7:0] == 8'h30) exp_frame = exp_frame & 64'h0000_ff00_ffff_ffff;
    end
  endfunction
  task frame(input [15:0] nxt, input hold);
    begin
      cnt = rx_count;
      comm_fault_in <= nxt[7:0];
      device_fault_in <= nxt[15:8];
      if (hold) begin
        repeat (20) @(posedge clk);
        chk(rx_count, cnt);
        apb(1'b1, `FREM_OFF_CTRL, {23'h0, 1'b1, 1'b0, node});
      end
      n = 0;
      while (rx_count === cnt) tick;
      chk(rx_id, 11'h080 + node);
      chk(rx_data, exp_frame(bits_now, nxt));
      bits_now = nxt;
    end
  endtask
  initial begin
    {rstn, psel, penable, pwrite, busoff_left_in, slow} = 6'h00;
    {paddr, pwdata} = 44'h0;
    {comm_fault_in, device_fault_in, bits_now} = 32'h0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb(1'b0, `FREM_OFF_CTRL, 32'h0);
    chk(rd, `FREM_CTRL_RST);
    apb(1'b0, 12'h01c, 32'h0);
    chk({err, rd}, 33'h100000000);
    $display("test registers done");
    // Frames wait while disabled, then every flag alone
    node = 7'($random(seed));
    frame(16'h0001, 1'b1);
    frame(16'h0000, 1'b0);
    for (i = 0; i < 16; i = i + 1) begin
      if (USED[i]) begin
        frame(16'h0001 << i, 1'b0);
        frame(16'h0000, 1'b0);
      end
    end
    for (i = 0; i < 16; i = i + 1) begin
      slow <= 1'($random(seed));
      rnd = 16'($random(seed)) & USED;
      if (rnd == bits_now) rnd = bits_now ^ 16'h0001;
      frame(rnd, 1'b0);
    end
    if (!bits_now[6]) frame(bits_now | 16'h0040, 1'b0);
    cnt = rx_count;
    busoff_left_in <= 1'b1;
    n = 0;
    while (rx_count === cnt) tick;
    chk(rx_data[47:40], `FREM_TRIG_BUSOFF_LEFT);
    busoff_left_in <= 1'b0;
    apb(1'b0, `FREM_OFF_COMM, 32'h0);
    chk(rd, {24'h0, bits_now[7:0]});
    apb(1'b0, `FREM_OFF_DEV, 32'h0);
    chk(rd, {24'h0, bits_now[15:8]});
    $display("test frames done");
    // Count slow pulses between two fast bursts
    for (i = 12; i < 19; i = i + 1) begin
      code = (i == 12) ? `FREM_CODE_CONFIG : i[4:0];
      arg = (i == 13) ? 8'h00 : 8'($random(seed)) & 8'h0f;
      f0 = fast_n;
      s0 = slow_n;
      apb(1'b1, `FREM_OFF_FAULT, {19'h0, arg, code});
      n = 0;
      while (fast_n < f0 + 9) tick;
      chk(slow_n - s0, code + arg);
      apb(1'b1, `FREM_OFF_FAULT, 32'h0);
      repeat (40) @(posedge clk);
    end
    $display("test lamp done");
    final_report(0);
  end
endmodule // frem_framer_tb

// ===== frem_map.vh
// Constants of the fault report and emergency framer block
`ifndef FREM_MAP_VH
`define FREM_MAP_VH
// ---------------------------------------------------------------
// APB register offsets (byte addresses)
// ---------------------------------------------------------------
`define FREM_OFF_CTRL      12'h000
`define FREM_OFF_FAULT     12'h004
`define FREM_OFF_STATUS    12'h008
`define FREM_OFF_FRAME_LO  12'h00c
`define FREM_OFF_FRAME_HI  12'h010
`define FREM_OFF_COMM      12'h014
`define FREM_OFF_DEV       12'h018
// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define FREM_CTRL_NODE_LSB 0
`define FREM_CTRL_NODE_MSB 6
`define FREM_CTRL_EN_BIT   8
`define FREM_CTRL_RST      32'h0000_0001
// ---------------------------------------------------------------
// Frame constants
// ---------------------------------------------------------------
`define FREM_EMCY_BASE     11'h080
`define FREM_EC_LOW_FULL   8'h00
`define FREM_EC_LOW_SHORT  8'h30
`define FREM_EC_HI_DEV     8'h50
`define FREM_EC_HI_COMM    8'h81
`define FREM_EC_HI_RESET   8'h00
`define FREM_ERROR_REGISTER_BYTE_DEV      8'h81
`define FREM_ERROR_REGISTER_BYTE_COMM     8'h91
`define FREM_TRIG_BUSOFF_LEFT 8'h40
`define FREM_BIT_BUSOFF    6
// ---------------------------------------------------------------
// Lamp fault codes and timing
// ---------------------------------------------------------------
`define FREM_CODE_CONFIG   5'd9
`define FREM_CODE_CMD      5'd13
`define FREM_CODE_FORMAT   5'd14
`define FREM_CODE_COUNT    5'd15
`define FREM_CODE_BITLEN   5'd16
`define FREM_CODE_TCOUNT   5'd17
`define FREM_CODE_DESCR    5'd18
`define FREM_FAST_NS       50000000
`define FREM_SLOW_NS       200000000
`define FREM_CLK_NS        10
`define FREM_FAST_PULSES   5'd8
`endif
